// ### logic/css_seq.sv
/*
  Sequencer for the non-opcode operations of the core: reset vector fetch,
  interrupt and soft trap entry, wait, stop, debug halt, paged call/return.
  Assumes the execution unit reports instruction boundaries and the register
  values to stack, and that memory answers reads with rdata_i next cycle.
*/
`timescale 1ns/1ps

// What this block does
// - Any reset aborts activity at once
// - Reset ends when sources done, pin released
// - Six cycles: reset vector, queue fill
// - Interrupt entered at instruction boundary only
// - Vector from lowest-numbered pending at entry
// - Push PC low, PC high, X, A, CONDITION_CODE_REG
// - Mask set after condition codes stacked
// - Vector high, low, free cycle, three fetches
// - Upper index byte never stacked
// - Soft trap same entry, ignores mask
// - Wait clears mask, stops core clock
// - Wake from wait runs normal sequence
// - Debug entry command wakes wait into debug
// - Stop may keep minimal clocks running
// - Debug enabled keeps oscillator in stop
// - Debug entry wakes stop with oscillator
// - Halt leaves debug on go command only
// - Paged call pushes return address low first
// - Paged call stacks old page, loads new
// - Paged call indivisible, refills queue
// - Paged return pulls page, address, refills
// - Halt enters debug only if enabled
// - Mask one means maskable interrupts disabled outside stop
module css_seq
  import css_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  input  wire logic               clock_i,
  input  wire logic               arst_n_i,
  input  wire logic               reset_req_i,
  input  wire logic               src_done_i,
  input  wire logic               reset_pin_n_i,
  input  wire logic [NUM_IRQ-1:0] irq_pend_i,
  input  wire logic [15:0]        irq_vec_i [NUM_IRQ],
  input  wire logic               boundary_i,
  input  wire css_op_t            op_i,
  input  wire logic [15:0]        next_pc_i,
  input  wire logic [15:0]        dest_pc_i,
  input  wire logic [7:0]         op_page_i,
  input  wire logic [7:0]         index_low_i,
  input  wire logic [7:0]         acc_i,
  input  wire logic [7:0]         ccr_i,
  input  wire logic               keep_clocks_i,
  input  wire logic               dbg_enable_set_i,
  input  wire logic               dbg_enter_cmd_i,
  input  wire logic               dbg_go_cmd_i,
  input  wire logic               wake_tick_i,
  input  wire logic [7:0]         rdata_i,
  output logic                    reset_active_o,
  output css_bus_t               bus_o,
  output logic                    mask_o,
  output logic                    cpu_clk_en_o,
  output logic                    osc_on_o,
  output logic                    debug_active_o,
  output logic                    seq_busy_o,
  output logic [15:0]             pc_o,
  output logic [7:0]              page_o,
  output logic [15:0]             sp_o
);

  css_state_t  state;
  css_op_t     op_kind;
  logic [2:0]  step;
  logic [15:0] vec_addr;
  logic [7:0]  vec_hi;
  logic        dbg_en;
  logic        resetting;
  logic [7:0]  pulled_page;

  function automatic logic [15:0] pick_vec(input logic [NUM_IRQ-1:0] pend,
                                           input logic [15:0] vecs [NUM_IRQ]);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (pend[i]) begin
        v = vecs[i];
      end
    end
    return v;
  endfunction

  wire logic        irq_take  = boundary_i && !mask_o && (|irq_pend_i);
  wire logic        wake_wait = (|irq_pend_i) || dbg_enter_cmd_i;
  wire logic        wake_stop = wake_tick_i && keep_clocks_i;
  wire logic [15:0] sel_vec   = pick_vec(irq_pend_i, irq_vec_i);
  wire logic        trap_take = boundary_i && op_i == CSS_OP_TRAP;
  wire logic [15:0] sp_dec    = sp_o - 16'h0001;
  wire logic [15:0] sp_inc    = sp_o + 16'h0001;
  // Low vector byte arrives in the first fill cycle
  wire logic [15:0] vec_word  = {vec_hi, rdata_i};
  wire logic        load_vec  = state == CSS_ST_FILL && step == 3'd0 && op_kind != CSS_OP_CALL;
  wire logic [15:0] fill_addr = load_vec ? vec_word : pc_o + 16'(step);

  // Stacked byte per push step; the upper index byte has no slot
  logic [7:0] push_byte;
  always_comb begin
    push_byte = 8'h00;
    case (step)
      3'd0: push_byte = pc_o[7:0];
      3'd1: push_byte = pc_o[15:8];
      3'd2: push_byte = (op_kind == CSS_OP_CALL) ? page_o : index_low_i;
      3'd3: push_byte = acc_i;
      default: push_byte = ccr_i;
    endcase
  end
  wire logic [2:0] push_last = (op_kind == CSS_OP_CALL) ? 3'd2 : 3'd4;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= CSS_ST_RESET;
      resetting <= 1'b1;
    end else if (reset_req_i || !reset_pin_n_i) begin
      state <= CSS_ST_RESET;
      resetting <= 1'b1;
    end else if (state == CSS_ST_RESET && src_done_i) begin
      state <= CSS_ST_RVEC_HI;
      resetting <= 1'b0;
    end else begin
      case (state)
        CSS_ST_RVEC_HI: state <= CSS_ST_RVEC_LO;
        CSS_ST_RVEC_LO: state <= CSS_ST_FREE;
        CSS_ST_FREE:    state <= CSS_ST_FILL;
        CSS_ST_FILL:    state <= (step == CSS_QUEUE_BYTES - 2'h1) ? CSS_ST_RUN : CSS_ST_FILL;
        CSS_ST_RUN: begin
          if (trap_take || irq_take) begin
            state <= CSS_ST_PUSH;
          end else if (boundary_i && op_i == CSS_OP_CALL) begin
            state <= CSS_ST_PUSH;
          end else if (boundary_i && op_i == CSS_OP_RTC) begin
            state <= CSS_ST_RTC_POP;
          end else if (boundary_i && op_i == CSS_OP_WAIT) begin
            state <= CSS_ST_WAIT;
          end else if (boundary_i && op_i == CSS_OP_STOP) begin
            state <= CSS_ST_STOP;
          end else if (boundary_i && op_i == CSS_OP_HALT && dbg_en) begin
            state <= CSS_ST_DEBUG;
          end
        end
        CSS_ST_PUSH: begin
          if (step == push_last) begin
            state <= (op_kind == CSS_OP_CALL) ? CSS_ST_FREE : CSS_ST_IVEC_HI;
          end
        end
        CSS_ST_IVEC_HI: state <= CSS_ST_IVEC_LO;
        CSS_ST_IVEC_LO: state <= CSS_ST_FREE;
        CSS_ST_RTC_POP: state <= (step == 3'd2) ? CSS_ST_FREE : CSS_ST_RTC_POP;
        CSS_ST_WAIT: begin
          if (dbg_enter_cmd_i) begin
            state <= CSS_ST_DEBUG;
          end else if (wake_wait) begin
            state <= CSS_ST_PUSH;
          end
        end
        CSS_ST_STOP: begin
          if (dbg_enter_cmd_i && dbg_en) begin
            state <= CSS_ST_DEBUG;
          end else if (wake_stop || (|irq_pend_i)) begin
            state <= CSS_ST_PUSH;
          end
        end
        CSS_ST_DEBUG:   state <= dbg_go_cmd_i ? CSS_ST_RUN : CSS_ST_DEBUG;
        default:        state <= CSS_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step <= 3'd0;
      op_kind <= CSS_OP_NONE;
      vec_addr <= 16'h0000;
      vec_hi <= 8'h00;
      pulled_page <= 8'h00;
    end else if (state == CSS_ST_RESET || (state == CSS_ST_RUN && boundary_i)) begin
      step <= 3'd0;
      if (state == CSS_ST_RESET) op_kind <= CSS_OP_NONE;
      else op_kind <= (trap_take || irq_take) ? CSS_OP_TRAP : op_i;
      vec_addr <= trap_take ? irq_vec_i[0] : sel_vec;
    end else if (state == CSS_ST_WAIT || state == CSS_ST_STOP) begin
      step <= 3'd0;
      op_kind <= CSS_OP_TRAP;
      vec_addr <= sel_vec;
    end else if (state == CSS_ST_PUSH || state == CSS_ST_RTC_POP || state == CSS_ST_FILL) begin
      step <= (state == CSS_ST_PUSH && step == push_last) ? 3'd0 : step + 3'd1;
      if (state == CSS_ST_RTC_POP && step == 3'd2) pulled_page <= rdata_i;
    end else begin
      step <= 3'd0;
      // Read data lags its request by two states
      if (state == CSS_ST_FREE) vec_hi <= rdata_i;
    end
  end

  // Bus cycle: one registered request per sequence cycle
  css_bus_t next_bus;
  always_comb begin
    next_bus = '{kind: CSS_CYC_IDLE, addr: 16'h0000, wdata: 8'h00};
    case (state)
      CSS_ST_RVEC_HI: next_bus = '{CSS_CYC_READ, CSS_RESET_VEC_HI, 8'h00};
      CSS_ST_RVEC_LO: next_bus = '{CSS_CYC_READ, CSS_RESET_VEC_LO, 8'h00};
      CSS_ST_PUSH:    next_bus = '{CSS_CYC_WRITE, sp_o, push_byte};
      CSS_ST_IVEC_HI: next_bus = '{CSS_CYC_READ, vec_addr, 8'h00};
      CSS_ST_IVEC_LO: next_bus = '{CSS_CYC_READ, vec_addr + 16'h0001, 8'h00};
      CSS_ST_RTC_POP: next_bus = '{CSS_CYC_READ, sp_inc, 8'h00};
      CSS_ST_FILL:    next_bus = '{CSS_CYC_READ, fill_addr, 8'h00};
      default:        ;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_o <= '{kind: CSS_CYC_IDLE, addr: 16'h0000, wdata: 8'h00};
      pc_o <= 16'h0000;
      sp_o <= CSS_SP_RESET;
      page_o <= CSS_PAGE_RESET;
      mask_o <= CSS_MASK_RESET;
      dbg_en <= CSS_DBG_EN_RESET;
    end else begin
      bus_o <= next_bus;
      if (dbg_enable_set_i) dbg_en <= 1'b1;
      if (state == CSS_ST_RESET) begin
        mask_o <= CSS_MASK_RESET;
        page_o <= CSS_PAGE_RESET;
      end else if (state == CSS_ST_RUN && boundary_i) begin
        pc_o <= next_pc_i;
        if (op_i == CSS_OP_WAIT && !trap_take && !irq_take) mask_o <= 1'b0;
      end else if (state == CSS_ST_PUSH) begin
        sp_o <= sp_dec;
        if (step == push_last && op_kind != CSS_OP_CALL) mask_o <= 1'b1;
        if (step == push_last && op_kind == CSS_OP_CALL) begin
          page_o <= op_page_i;
          pc_o <= dest_pc_i;
        end
      end else if (state == CSS_ST_RTC_POP) begin
        sp_o <= sp_inc;
      end else if (load_vec) begin
        pc_o <= vec_word;
        if (op_kind == CSS_OP_RTC) page_o <= pulled_page;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_active_o <= 1'b1;
      cpu_clk_en_o <= 1'b0;
      osc_on_o <= 1'b1;
      debug_active_o <= 1'b0;
      seq_busy_o <= 1'b1;
    end else begin
      reset_active_o <= resetting;
      cpu_clk_en_o <= !(state == CSS_ST_WAIT || state == CSS_ST_STOP || state == CSS_ST_RESET);
      osc_on_o <= (state != CSS_ST_STOP) || dbg_en || keep_clocks_i;
      debug_active_o <= (state == CSS_ST_DEBUG);
      seq_busy_o <= (state != CSS_ST_RUN);
    end
  end

  property p_push_order;
    @(posedge clock_i) disable iff (!arst_n_i)
      (state == CSS_ST_PUSH && step == 3'd0 && op_kind == CSS_OP_TRAP) |=> step == 3'd1;
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order broken");

  property p_mask_after_push;
    @(posedge clock_i) disable iff (!arst_n_i)
      (state == CSS_ST_PUSH && step == 3'd4 && op_kind == CSS_OP_TRAP) |=> mask_o;
  endproperty
  a_mask_after_push: assert property (p_mask_after_push) else $error("mask not set");

  property p_reset_abort;
    @(posedge clock_i) disable iff (!arst_n_i) reset_req_i |=> state == CSS_ST_RESET;
  endproperty
  a_reset_abort: assert property (p_reset_abort) else $error("reset not immediate");

  property p_halt_gated;
    @(posedge clock_i) disable iff (!arst_n_i)
      (state == CSS_ST_RUN && !dbg_en) |=> state != CSS_ST_DEBUG;
  endproperty
  a_halt_gated: assert property (p_halt_gated) else $error("debug without enable");

  property p_osc_stop;
    @(posedge clock_i) disable iff (!arst_n_i) (state == CSS_ST_STOP && dbg_en) |=> osc_on_o;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator stopped");

  property p_reset_seq;
    @(posedge clock_i) disable iff (!arst_n_i || reset_req_i || !reset_pin_n_i)
      (state == CSS_ST_RVEC_HI) |=> state == CSS_ST_RVEC_LO ##1 state == CSS_ST_FREE;
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset vector order");

  property p_wait_mask;
    @(posedge clock_i) disable iff (!arst_n_i) (state == CSS_ST_WAIT) |-> !mask_o;
  endproperty
  a_wait_mask: assert property (p_wait_mask) else $error("wait left mask set");

  property p_no_irq_masked;
    @(posedge clock_i) disable iff (!arst_n_i || reset_req_i || !reset_pin_n_i)
      (state == CSS_ST_RUN && mask_o && boundary_i && op_i == CSS_OP_NONE) |=> state == CSS_ST_RUN;
  endproperty
  a_no_irq_masked: assert property (p_no_irq_masked) else $error("masked irq taken");

  c_irq:  cover property (@(posedge clock_i) state == CSS_ST_IVEC_HI);
  c_call: cover property (@(posedge clock_i) state == CSS_ST_PUSH && op_kind == CSS_OP_CALL);
  c_rtc:  cover property (@(posedge clock_i) state == CSS_ST_RTC_POP);
  c_dbg:  cover property (@(posedge clock_i) state == CSS_ST_DEBUG);

endmodule

// ### logic/css_pkg.sv
/*
  Package for the special-sequence control of a small 8-bit core:
  state enumeration, bus cycle kinds, vector and window addresses.
  Assumes a 16-bit address bus with 8-bit data and one bus clock.
*/
package css_pkg;

  localparam logic [15:0] CSS_RESET_VEC_HI  = 16'hfffe;
  localparam logic [15:0] CSS_RESET_VEC_LO  = 16'hffff;
  localparam logic [15:0] CSS_WINDOW_START  = 16'h8000;
  localparam logic [15:0] CSS_WINDOW_END    = 16'hbfff;
  localparam logic [1:0]  CSS_QUEUE_BYTES   = 2'h3;
  localparam logic [7:0]  CSS_PAGE_RESET    = 8'h00;
  localparam logic [15:0] CSS_SP_RESET      = 16'h00ff;
  localparam logic        CSS_MASK_RESET    = 1'b1;
  localparam logic        CSS_DBG_EN_RESET  = 1'b0;

  // Kind of bus cycle that the sequencer drives
  typedef enum logic [1:0] {
    CSS_CYC_IDLE,
    CSS_CYC_READ,
    CSS_CYC_WRITE
  } css_cyc_t;

  typedef struct packed {
    css_cyc_t    kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } css_bus_t;

  typedef enum {
    CSS_ST_RESET,
    CSS_ST_RVEC_HI,
    CSS_ST_RVEC_LO,
    CSS_ST_FREE,
    CSS_ST_FILL,
    CSS_ST_RUN,
    CSS_ST_PUSH,
    CSS_ST_IVEC_HI,
    CSS_ST_IVEC_LO,
    CSS_ST_WAIT,
    CSS_ST_STOP,
    CSS_ST_DEBUG,
    CSS_ST_RTC_POP
  } css_state_t;

  // Operation requested at an instruction boundary
  typedef enum logic [2:0] {
    CSS_OP_NONE,
    CSS_OP_TRAP,
    CSS_OP_WAIT,
    CSS_OP_STOP,
    CSS_OP_HALT,
    CSS_OP_CALL,
    CSS_OP_RTC
  } css_op_t;

endpackage

// ### verification/css_partner.sv
/*
  Far-side model: memory answering reads one cycle later and keeping
  writes, plus the reset-source logic. Assumes one bus clock.
*/
`timescale 1ns/1ps
module css_partner
  import css_pkg::*;
#(
  parameter int SRC_CYCLES = 4
) (
  input  wire logic     clock_i,
  input  wire logic     arst_n_i,
  input  wire css_bus_t bus_i,
  output logic [7:0]    rdata_o,
  output logic          src_done_o
);
  logic [7:0] mem [65536];
  bit         held [65536];
  int         cnt;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt        <= 0;
      src_done_o <= 1'b0;
      rdata_o    <= 8'h5a;
    end else begin
      cnt        <= cnt + 1;
      src_done_o <= (cnt >= SRC_CYCLES);
      if (bus_i.kind == CSS_CYC_WRITE) begin
        mem[bus_i.addr]  <= bus_i.wdata;
        held[bus_i.addr] <= 1'b1;
      end
      // Idle cycles show changing junk
      if (bus_i.kind != CSS_CYC_READ)
        rdata_o <= ~rdata_o;
      else if (held[bus_i.addr])
        rdata_o <= mem[bus_i.addr];
      else
        rdata_o <= bus_i.addr[7:0] + bus_i.addr[15:8];
    end
  end
endmodule

// ### verification/cpu_special_sequence_control_bench.sv
/*
  Self-checking bench: expected bus cycles from a queue model.
  Assumes css_seq and css_partner, one 50 MHz clock.
*/
`timescale 1ns/1ps
module cpu_special_sequence_control_bench
  import css_pkg::*;
;
  typedef struct {int gap; int kind; int addr; int wdata;} css_ev_t;
  logic        clock_i = 0, arst_n = 0, reset_req = 0, pin_n = 0, boundary = 0;
  logic        dbg_set = 0, dbg_enter = 0, dbg_go = 0, keep = 0, tick = 0;
  logic [7:0]  irq_pend = 0, page = 0, idx = 0, acc = 0, condition_code_reg = 0;
  logic [15:0] vec [8], next_pc = 0, dest_pc = 0;
  css_op_t     op = CSS_OP_NONE;
  wire logic [7:0] rdata, page_o;
  wire logic       src_done, rst_act, mask, clk_en, osc, dbg_act, busy;
  wire logic [15:0] pc_o, sp_o;
  css_bus_t    bus;
  css_ev_t     seen[$], exp[$];
  int          fails = 0, checked = 0, cyc = 0, last = 0;

  css_seq #(.NUM_IRQ(8)) dut (.clock_i(clock_i), .arst_n_i(arst_n), .reset_req_i(reset_req),
    .src_done_i(src_done), .reset_pin_n_i(pin_n), .irq_pend_i(irq_pend), .irq_vec_i(vec),
    .boundary_i(boundary), .op_i(op), .next_pc_i(next_pc), .dest_pc_i(dest_pc),
    .op_page_i(page), .index_low_i(idx), .acc_i(acc), .ccr_i(condition_code_reg), .keep_clocks_i(keep),
    .dbg_enable_set_i(dbg_set), .dbg_enter_cmd_i(dbg_enter), .dbg_go_cmd_i(dbg_go),
    .wake_tick_i(tick), .rdata_i(rdata), .reset_active_o(rst_act), .bus_o(bus),
    .mask_o(mask), .cpu_clk_en_o(clk_en), .osc_on_o(osc), .debug_active_o(dbg_act),
    .seq_busy_o(busy), .pc_o(pc_o), .page_o(page_o), .sp_o(sp_o));
  css_partner far (.clock_i(clock_i), .arst_n_i(arst_n), .bus_i(bus), .rdata_o(rdata),
    .src_done_o(src_done));

  initial forever #10 clock_i = ~clock_i;
  always @(negedge clock_i) begin
    cyc++;
    if (bus.kind != CSS_CYC_IDLE) begin
      seen.push_back('{cyc - last, int'(bus.kind), int'(bus.addr), int'(bus.wdata)});
      last = cyc;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, got, want);
    end
  endtask
  function automatic logic [15:0] pat2(input logic [15:0] a);
    return {a[7:0] + a[15:8], a[7:0] + 8'h01 + a[15:8]};
  endfunction
  task automatic rd(input int a, input int g);
    exp.push_back('{g, 1, a, -1});
  endtask
  task automatic wr(input int d);
    exp.push_back('{-1, 2, -1, d});
  endtask
  task automatic fill(input logic [15:0] v, input int g);
    for (int i = 0; i < 3; i++) rd(int'(v) + i, (i == 0) ? g : -1);
  endtask
  task automatic entry(input logic [15:0] va);
    wr(next_pc[7:0]); wr(next_pc[15:8]); wr(idx); wr(acc); wr(condition_code_reg);
    rd(va, -1); rd(int'(va) + 1, -1); fill(pat2(va), 2);
  endtask
  task automatic settle;
    int n;
    n = 0;
    repeat (3) @(negedge clock_i);
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    check(n < 300, 1);
    check(seen.size(), exp.size());
    for (int i = 0; i < exp.size() && i < seen.size(); i++) begin
      check(seen[i].kind, exp[i].kind);
      if (exp[i].gap >= 0) check(seen[i].gap, exp[i].gap);
      if (exp[i].addr >= 0) check(seen[i].addr, exp[i].addr);
      if (exp[i].wdata >= 0) check(seen[i].wdata, exp[i].wdata);
    end
    seen.delete();
    exp.delete();
  endtask
  task automatic run_op(input css_op_t o);
    @(posedge clock_i);
    boundary <= 1'b1;
    op       <= o;
    @(posedge clock_i);
    boundary <= 1'b0;
    op       <= CSS_OP_NONE;
  endtask
  // One-cycle pulse: 0 debug enable, 1 go, 2 debug entry, else wake tick
  task automatic pulse(input int w);
    @(posedge clock_i);
    case (w)
      0: dbg_set <= 1'b1;
      1: dbg_go <= 1'b1;
      2: dbg_enter <= 1'b1;
      default: tick <= 1'b1;
    endcase
    @(posedge clock_i);
    {dbg_set, dbg_go, dbg_enter, tick} <= 4'h0;
    repeat (4) @(negedge clock_i);
  endtask
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    fails++;
    final_report();
  end

  initial begin
    logic [15:0] ret2;
    void'($urandom(32'h7782bd5c));
    for (int k = 0; k < 8; k++) vec[k] = 16'h2000 + 16'(k * 4);
    repeat (3) @(posedge clock_i);
    arst_n <= 1'b1;
    repeat (12) @(negedge clock_i);
    check(rst_act, 1);
    rd(16'hfffe, -1); rd(16'hffff, 1); fill(pat2(16'hfffe), 2);
    @(posedge clock_i) pin_n <= 1'b1;
    settle();
    check(mask, 1);
    irq_pend <= 8'h24;
    run_op(CSS_OP_NONE);
    settle();
    irq_pend <= 8'h00;
    {next_pc, idx, acc, condition_code_reg} = 40'({$urandom, $urandom});
    run_op(CSS_OP_WAIT);
    repeat (4) @(negedge clock_i);
    check({mask, clk_en}, 2'b00);
    seen.delete();
    entry(vec[2]);
    irq_pend <= 8'h24;
    settle();
    check(mask, 1);
    irq_pend <= 8'h00;
    {next_pc, idx, acc, condition_code_reg} = 40'({$urandom, $urandom});
    entry(vec[0]);
    run_op(CSS_OP_TRAP);
    settle();
    next_pc = 16'($urandom);
    dest_pc = 16'h8100;
    page    = 8'h05;
    wr(next_pc[7:0]); wr(next_pc[15:8]); wr(0); fill(dest_pc, -1);
    run_op(CSS_OP_CALL);
    settle();
    check(page_o, 8'h05);
    ret2    = 16'h8000 + 16'($urandom % 16'h3ffd);
    next_pc = ret2;
    dest_pc = 16'hbf00;
    page    = 8'h09;
    wr(ret2[7:0]); wr(ret2[15:8]); wr(5); fill(dest_pc, -1);
    run_op(CSS_OP_CALL);
    settle();
    rd(-1, -1); rd(-1, -1); rd(-1, -1); fill(ret2, -1);
    run_op(CSS_OP_RTC);
    settle();
    check({page_o, pc_o}, {8'h05, ret2});
    check(sp_o, CSS_SP_RESET - 16'h000d);
    run_op(CSS_OP_HALT);
    repeat (4) @(negedge clock_i);
    check(dbg_act, 0);
    // Stop with clocks kept: periodic tick wakes into entry
    keep <= 1'b1;
    run_op(CSS_OP_STOP);
    repeat (4) @(negedge clock_i);
    check({clk_en, osc}, 2'b01);
    entry(16'h0000);
    pulse(3);
    keep <= 1'b0;
    settle();
    pulse(0);
    run_op(CSS_OP_HALT);
    repeat (4) @(negedge clock_i);
    check(dbg_act, 1);
    pulse(1);
    check(dbg_act, 0);
    for (int m = 0; m < 2; m++) begin
      run_op(m == 0 ? CSS_OP_WAIT : CSS_OP_STOP);
      repeat (4) @(negedge clock_i);
      check({clk_en, osc}, 2'b01);
      pulse(2);
      check(dbg_act, 1);
      pulse(1);
    end
    run_op(CSS_OP_TRAP);
    repeat (3) @(posedge clock_i);
    reset_req <= 1'b1;
    repeat (3) @(negedge clock_i);
    check({rst_act, bus.kind}, {1'b1, CSS_CYC_IDLE});
    seen.delete();
    rd(16'hfffe, -1); rd(16'hffff, 1); fill(pat2(16'hfffe), 2);
    @(posedge clock_i) reset_req <= 1'b0;
    settle();
    final_report();
  end
endmodule
